// [core/aprsr_top.sv]
`timescale 1ns/10ps
module aprsr_top
    import aprsr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [aprsr_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [aprsr_pkg::DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [aprsr_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Serial input, one bit per i_bit_valid
    input wire logic i_bit_valid,
    input wire logic i_fsync,
    input wire logic i_sdata,
    // Playback converter channels 6..8
    output logic [aprsr_pkg::NUM_CH-1:0] o_dac_valid,
    output logic [aprsr_pkg::NUM_CH-1:0][aprsr_pkg::DATA_W-1:0] o_dac_data,
    // Loopback of recording converter channels 2..4
    output logic [aprsr_pkg::NUM_CH-1:0] o_loop_valid,
    output logic [aprsr_pkg::NUM_CH-1:0][aprsr_pkg::DATA_W-1:0] o_loop_data,
    // Linked peer devices 1..3
    output logic [aprsr_pkg::NUM_CH-1:0] o_peer_valid,
    output logic [aprsr_pkg::NUM_CH-1:0][aprsr_pkg::DATA_W-1:0] o_peer_data,
    // Frame tracking status
    output logic o_frame_locked
);

    import aprsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register file

    localparam logic [NUM_CH-1:0][CFG_W-1:0] CFG_RST =
        {RST_CH8, RST_CH7, RST_CH6};

    logic [NUM_CH-1:0][CFG_W-1:0] cfg;
    logic [3:0] frame_ctl;

    wire [5:0] idx;
    wire setup;
    wire access;
    wire wr_en;
    wire [NUM_CH-1:0] hit_ch;
    wire hit_frame;
    wire hit_any;
    wire [DATA_W-1:0] rd_mux;

    assign idx = i_paddr[IDX_LSB+5:IDX_LSB];
    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;
    assign hit_ch[0] = (idx == IDX_CH6);
    assign hit_ch[1] = (idx == IDX_CH7);
    assign hit_ch[2] = (idx == IDX_CH8);
    assign hit_frame = (idx == IDX_FRAME);
    assign hit_any = |hit_ch | hit_frame;
    assign wr_en = access & i_pwrite & hit_any & i_pstrb[0];

    // Bit seven never stored, so it reads as zero
    assign rd_mux = hit_ch[0] ? {25'h0, cfg[0]} :
                    hit_ch[1] ? {25'h0, cfg[1]} :
                    hit_ch[2] ? {25'h0, cfg[2]} :
                    hit_frame ? {28'h0, frame_ctl} : '0;

    assign o_pready = 1'b1;
    assign o_pslverr = access & ~hit_any;

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_cfg
            always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    cfg[c] <= CFG_RST[c];
                end else if (i_clk_en && wr_en && hit_ch[c]) begin
                    cfg[c] <= i_pwdata[CFG_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            frame_ctl <= RST_FRAME;
            o_prdata <= '0;
        end else if (i_clk_en) begin
            if (wr_en && hit_frame) begin
                frame_ctl <= i_pwdata[3:0];
            end
            // Read data is taken in the setup cycle, ready in the access
            if (setup) begin
                o_prdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame tracking

    aprsr_fmt_t fmt;
    logic [4:0] last_idx;
    logic fsync_d;
    logic prev_fr;
    logic [4:0] bit_cnt;
    logic [4:0] slot_cnt;

    wire fr;
    wire edge_rise;
    wire edge_any;
    wire half_start;
    wire frame_start;
    wire [4:0] cur_bit;
    wire [4:0] cur_slot;
    wire cur_right;
    wire is_tdm;
    wire is_i2s;
    wire last_bit;
    wire bit_ok;

    assign fmt = aprsr_fmt_t'(frame_ctl[FMT_LSB+1:FMT_LSB]);

    always_comb begin
        case (frame_ctl[WLEN_LSB+1:WLEN_LSB])
            2'h0: last_idx = LAST_16;
            2'h1: last_idx = LAST_20;
            2'h2: last_idx = LAST_24;
            default: last_idx = LAST_32;
        endcase
    end

    assign is_tdm = (fmt == APRSR_FMT_TDM);
    assign is_i2s = (fmt == APRSR_FMT_I2S);
    // I2S data trails its frame-sync edge by one bit
    assign fr = is_i2s ? fsync_d : i_fsync;
    assign edge_rise = fr & ~prev_fr;
    assign edge_any = fr ^ prev_fr;
    assign half_start = i_bit_valid & (is_tdm ? edge_rise : edge_any);
    // Left half opens on low sync in I2S, high sync otherwise
    assign frame_start = half_start & (is_i2s ? ~fr : fr);
    assign cur_bit = half_start ? 5'h0 : bit_cnt;
    assign cur_slot = half_start ? 5'h0 : slot_cnt;
    assign cur_right = ~is_tdm & (is_i2s ? fr : ~fr);
    assign last_bit = (cur_bit == last_idx);
    assign bit_ok = i_bit_valid & (o_frame_locked | frame_start);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fsync_d <= 1'b0;
            prev_fr <= 1'b0;
            bit_cnt <= '0;
            slot_cnt <= '0;
            o_frame_locked <= 1'b0;
        end else if (i_clk_en && i_bit_valid) begin
            fsync_d <= i_fsync;
            prev_fr <= fr;
            bit_cnt <= last_bit ? 5'h0 : cur_bit + 5'h1;
            slot_cnt <= last_bit ? cur_slot + 5'h1 : cur_slot;
            if (frame_start) begin
                o_frame_locked <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stream to the capture units

    aprsr_stream_if stream ();

    assign stream.bit_valid = bit_ok;
    assign stream.sdata = i_sdata;
    assign stream.last_bit = last_bit;
    // Half-frame slots map to 0..15 left, 16..31 right
    assign stream.slot = is_tdm ? cur_slot :
                         {cur_right, cur_slot[HALF_SLOT_W-1:0]};
    // Slots past fifteen in a half frame match no field value
    assign stream.in_range = is_tdm | ~cur_slot[HALF_SLOT_W];

    ////////////////////////////////////////////////////////////////////////
    // Per-channel capture and routing

    logic [NUM_CH-1:0][CFG_W-1:0] act;

    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            wire [CFG_W-1:0] use_cfg;
            wire [ROUTE_W-1:0] route;
            wire [DATA_W-1:0] word;
            wire done;

            // Settings move to the active copy only as a frame opens
            assign use_cfg = frame_start ? cfg[c] : act[c];
            assign route = act[c][ROUTE_LSB+ROUTE_W-1:ROUTE_LSB];

            always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    act[c] <= CFG_RST[c];
                end else if (i_clk_en && frame_start) begin
                    act[c] <= cfg[c];
                end
            end

            aprsr_slot_capture u_cap (
                .i_sys_clk(i_sys_clk),
                .i_reset_n(i_reset_n),
                .i_clk_en(i_clk_en),
                .stream(stream),
                .i_enable(use_cfg[ROUTE_LSB+ROUTE_W-1:ROUTE_LSB] !=
                          ROUTE_OFF),
                .i_slot_sel(use_cfg[SLOT_LSB+SLOT_W-1:SLOT_LSB]),
                .o_word(word),
                .o_done(done)
            );

            // Index c: playback 6+c, loopback of recording 2+c, peer 1+c
            always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    o_dac_valid[c] <= 1'b0;
                    o_loop_valid[c] <= 1'b0;
                    o_peer_valid[c] <= 1'b0;
                    o_dac_data[c] <= '0;
                    o_loop_data[c] <= '0;
                    o_peer_data[c] <= '0;
                end else if (i_clk_en) begin
                    o_dac_valid[c] <= done && route == ROUTE_DAC;
                    o_loop_valid[c] <= done && route == ROUTE_LOOP;
                    o_peer_valid[c] <= done && route == ROUTE_PEER;
                    if (done && route == ROUTE_DAC) begin
                        o_dac_data[c] <= word;
                    end
                    if (done && route == ROUTE_LOOP) begin
                        o_loop_data[c] <= word;
                    end
                    if (done && route == ROUTE_PEER) begin
                        o_peer_data[c] <= word;
                    end
                end
            end
        end
    endgenerate

endmodule

// [core/aprsr_pkg.sv]
package aprsr_pkg;

    // APB data and address
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int IDX_LSB = 2;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_CH6 = 6'h2d;
    localparam logic [5:0] IDX_CH7 = 6'h2e;
    localparam logic [5:0] IDX_CH8 = 6'h2f;
    localparam logic [5:0] IDX_FRAME = 6'h30;

    // Channel configuration fields
    localparam int NUM_CH = 3;
    localparam int SLOT_LSB = 0;
    localparam int SLOT_W = 5;
    localparam int ROUTE_LSB = 5;
    localparam int ROUTE_W = 2;
    localparam int CFG_W = 7;
    localparam logic [6:0] RST_CH6 = 7'h05;
    localparam logic [6:0] RST_CH7 = 7'h06;
    localparam logic [6:0] RST_CH8 = 7'h07;

    // Routing field codes
    localparam logic [1:0] ROUTE_OFF = 2'h0;
    localparam logic [1:0] ROUTE_DAC = 2'h1;
    localparam logic [1:0] ROUTE_LOOP = 2'h2;
    localparam logic [1:0] ROUTE_PEER = 2'h3;

    // Frame control register fields
    localparam int FMT_LSB = 0;
    localparam int WLEN_LSB = 2;
    localparam logic [3:0] RST_FRAME = 4'h0;

    typedef enum logic [1:0] {
        APRSR_FMT_TDM = 2'h0,
        APRSR_FMT_I2S = 2'h1,
        APRSR_FMT_LJ = 2'h2,
        APRSR_FMT_RSVD = 2'h3
    } aprsr_fmt_t;

    // Word length codes and their last bit index
    localparam logic [4:0] LAST_16 = 5'h0f;
    localparam logic [4:0] LAST_20 = 5'h13;
    localparam logic [4:0] LAST_24 = 5'h17;
    localparam logic [4:0] LAST_32 = 5'h1f;

    // Slot number bits per half frame in I2S and left-justified framing
    localparam int HALF_SLOT_W = 4;

endpackage

// [core/aprsr_stream_if.sv]
`timescale 1ns/10ps
interface aprsr_stream_if;
    logic bit_valid;
    logic sdata;
    logic [4:0] slot;
    logic in_range;
    logic last_bit;

    modport framer (
        output bit_valid,
        output sdata,
        output slot,
        output in_range,
        output last_bit
    );
    modport capture (
        input bit_valid,
        input sdata,
        input slot,
        input in_range,
        input last_bit
    );
endinterface

// [core/aprsr_slot_capture.sv]
`timescale 1ns/10ps
module aprsr_slot_capture
    import aprsr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Serial stream
    aprsr_stream_if.capture stream,
    // Channel selection
    input wire logic i_enable,
    input wire logic [SLOT_W-1:0] i_slot_sel,
    // Captured word
    output logic [DATA_W-1:0] o_word,
    output logic o_done
);

    logic [DATA_W-1:0] shift;
    wire hit;
    wire [DATA_W-1:0] next_shift;

    // A disabled channel never captures
    assign hit = stream.bit_valid & i_enable & stream.in_range &
                 (stream.slot == i_slot_sel);
    assign next_shift = {shift[DATA_W-2:0], stream.sdata};

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift <= '0;
            o_word <= '0;
            o_done <= 1'b0;
        end else if (i_clk_en) begin
            o_done <= hit & stream.last_bit;
            if (hit) begin
                shift <= stream.last_bit ? '0 : next_shift;
            end
            if (hit && stream.last_bit) begin
                o_word <= next_shift;
            end
        end
    end

endmodule

// [verification/aprsr_assertions.sv]
`timescale 1ns/10ps
module aprsr_assertions
    import aprsr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [aprsr_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [aprsr_pkg::DATA_W-1:0] o_prdata,
    input wire logic o_pslverr,
    // Stream and deliveries
    input wire logic i_bit_valid,
    input wire logic [aprsr_pkg::NUM_CH-1:0] o_dac_valid,
    input wire logic [aprsr_pkg::NUM_CH-1:0] o_loop_valid,
    input wire logic [aprsr_pkg::NUM_CH-1:0] o_peer_valid,
    input wire logic [aprsr_pkg::NUM_CH-1:0][aprsr_pkg::DATA_W-1:0]
        o_dac_data,
    input wire logic o_frame_locked
);
    import aprsr_pkg::*;
    logic mapped;
    logic [NUM_CH-1:0] any_v;
    assign mapped = i_paddr[7:2] >= IDX_CH6 && i_paddr[7:2] <= IDX_FRAME;
    assign any_v = o_dac_valid | o_loop_valid | o_peer_valid;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////
    a_err_unmapped: assert property (
        i_psel && i_penable && !mapped |-> o_pslverr) else $error("no err");
    a_err_mapped: assert property (
        i_psel && i_penable && mapped |-> !o_pslverr) else $error("bad err");
    a_rsv_zero: assert property (
        o_prdata[31:CFG_W] == '0) else $error("reserved read bits set");
    a_one_dest: assert property (
        ((o_dac_valid & o_loop_valid) | (o_peer_valid & (o_dac_valid
        | o_loop_valid))) == '0) else $error("two destinations");
    a_out_after_bit: assert property (
        any_v != '0 |-> $past(i_bit_valid && i_clk_en, 2))
        else $error("delivery without a bit");
    a_out_locked: assert property (
        any_v != '0 |-> o_frame_locked) else $error("delivery unlocked");
    a_pulse_once: assert property (
        any_v != '0 && i_clk_en |=> (any_v & $past(any_v)) == '0)
        else $error("valid too long");
    a_freeze_hold: assert property (
        !i_clk_en |=> $stable(o_dac_data) && $stable(o_frame_locked))
        else $error("state moved while frozen");
    a_data_cause: assert property (
        o_dac_data != $past(o_dac_data) |-> o_dac_valid != '0)
        else $error("data moved without valid");
    a_lock_holds: assert property (
        o_frame_locked |=> o_frame_locked) else $error("lock lost");
endmodule

bind aprsr_top aprsr_assertions u_aprsr_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_bit_valid(i_bit_valid),
    .o_dac_valid(o_dac_valid), .o_loop_valid(o_loop_valid),
    .o_peer_valid(o_peer_valid), .o_dac_data(o_dac_data),
    .o_frame_locked(o_frame_locked)
);

// [verification/aprsr_host_model.sv]
`timescale 1ns/10ps
module aprsr_host_model
    import aprsr_pkg::*;
(
    // Clock and control
    input wire logic i_sys_clk,
    input wire logic i_run,
    input wire logic i_slow,
    input wire logic [1:0] i_fmt,
    input wire logic [15:0] i_seed,
    // Serial frame, 16-bit slots
    output logic o_bit_valid,
    output logic o_fsync,
    output logic o_sdata,
    output int o_frames
);
    import aprsr_pkg::*;
    logic [8:0] b = 9'h1fe;
    logic [8:0] nb;
    logic [15:0] w;
    logic gap = 1'b0;
    // Half then slot equals the TDM slot, so one word table serves all
    assign nb = b + 9'h1;
    assign w = i_seed ^ ({11'h0, b[8:4]} * 16'h0911);
    initial begin
        o_bit_valid = 1'b0;
        o_fsync = 1'b1;
        o_sdata = 1'b0;
        o_frames = -1;
    end
    ////////////////////////////////
    // Starts two bits before a frame: the delayed I2S sync must see its fall
    always @(posedge i_sys_clk) begin
        if (!i_run || gap) begin
            o_bit_valid <= 1'b0;
            o_sdata <= ~o_sdata;
            gap <= 1'b0;
            if (!i_run) begin
                b <= 9'h1fe;
                o_fsync <= 1'b1;
                o_frames <= -1;
            end
        end else begin
            o_bit_valid <= 1'b1;
            o_sdata <= w[~b[3:0]];
            gap <= i_slow;
            b <= nb;
            if (b == 9'h1ff)
                o_frames <= o_frames + 1;
            case (i_fmt)
                APRSR_FMT_TDM: o_fsync <= (b == 9'h0);
                APRSR_FMT_I2S: o_fsync <= nb[8];
                default: o_fsync <= ~b[8];
            endcase
        end
    end
endmodule

// [verification/aprsr_top_tb.sv]
`timescale 1ns/10ps
module aprsr_top_tb;
    import aprsr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, bit_valid, fsync, sdata, locked;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic [1:0] fmt = 2'h0;
    logic [15:0] seed = 16'h0;
    logic [NUM_CH-1:0] dac_v, loop_v, peer_v;
    logic [NUM_CH-1:0][DATA_W-1:0] dac_d, loop_d, peer_d;
    logic [31:0] rnd = 32'h0040;
    logic [6:0] cfg [NUM_CH];
    logic [1:0] ftab [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
    logic [6:0] ctab [4][NUM_CH] = '{'{7'h20, 7'h5f, 7'h70},
        '{7'h6f, 7'h30, 7'h5f}, '{7'h40, 7'h71, 7'h25}, '{7'h09, 7'h21, 7'h09}};
    int frames, n;
    int hits [NUM_CH];
    int bad_count = 0;
    int checks_done = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    aprsr_top dut (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_bit_valid(bit_valid), .i_fsync(fsync), .i_sdata(sdata),
        .o_dac_valid(dac_v), .o_dac_data(dac_d), .o_loop_valid(loop_v),
        .o_loop_data(loop_d), .o_peer_valid(peer_v),
        .o_peer_data(peer_d), .o_frame_locked(locked)
    );
    aprsr_host_model u_host (
        .i_sys_clk(clk), .i_run(run), .i_slow(slow), .i_fmt(fmt),
        .i_seed(seed), .o_bit_valid(bit_valid), .o_fsync(fsync),
        .o_sdata(sdata), .o_frames(frames)
    );
    ////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] ew(input logic [4:0] s);
        return {16'h0, seed ^ ({11'h0, s[4], s[3:0]} * 16'h0911)};
    endfunction
    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            cmp(0, 1, "apb timeout");
            finish_test;
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic chk(input logic v, input logic [1:0] g, input int k,
                       input logic [31:0] d);
        if (v === 1'b1) begin
            hits[k]++;
            cmp(32'(cfg[k][6:5]), 32'(g), "dest");
            cmp(d, ew(cfg[k][4:0]), "word");
        end
    endtask
    always @(posedge clk) begin
        for (int k = 0; k < NUM_CH; k++) begin
            chk(dac_v[k] & rst_n, ROUTE_DAC, k, dac_d[k]);
            chk(loop_v[k] & rst_n, ROUTE_LOOP, k, loop_d[k]);
            chk(peer_v[k] & rst_n, ROUTE_PEER, k, peer_d[k]);
        end
    end
    ////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < NUM_CH; k++) begin
            apb(1'b0, 8'hb4 + 8'(4 * k), 0);
            cmp(rd, 32'h5 + 32'(k), "reset value");
        end
        apb(1'b1, 8'hb4, 32'hff7f);
        apb(1'b0, 8'hb4, 0);
        cmp(rd, 32'h7f, "reserved bit");
        pstrb <= 4'he;
        apb(1'b1, 8'hb4, 0);
        pstrb <= 4'hf;
        apb(1'b0, 8'hb4, 0);
        cmp(rd, 32'h7f, "masked write");
        apb(1'b0, 8'h00, 0);
        cmp({rd[30:0], err}, 32'h1, "unmapped");
        apb(1'b1, 8'hc0, 32'hf);
        apb(1'b0, 8'hc0, 0);
        cmp(rd, 32'hf, "frame register");
        $display("Register test done");
        // Four corner runs, then random ones; reset between runs
        for (int r = 0; r < 10; r++) begin
            rst_n <= 1'b0;
            rnd = xs(rnd);
            seed <= rnd[15:0];
            fmt <= (r < 4) ? ftab[r] : rnd[17:16];
            slow <= rnd[20];
            rnd = xs(rnd);
            for (int k = 0; k < NUM_CH; k++) begin
                cfg[k] = (r < 4) ? ctab[r][k] : rnd[7 * k +: 7];
                hits[k] = 0;
            end
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            clk_en <= 1'b0;
            repeat (3) @(posedge clk);
            clk_en <= 1'b1;
            apb(1'b1, 8'hc0, {30'h0, fmt});
            for (int k = 0; k < NUM_CH; k++)
                apb(1'b1, 8'hb4 + 8'(4 * k), {25'h0, cfg[k]});
            run <= 1'b1;
            for (n = 0; n < 5000 && frames < 2; n++)
                @(posedge clk);
            cmp(32'(frames), 32'h2, "frames sent");
            cmp(32'(locked), 32'h1, "locked");
            run <= 1'b0;
            repeat (4) @(posedge clk);
            for (int k = 0; k < NUM_CH; k++)
                cmp(hits[k], (cfg[k][6:5] != 0) ? 2 : 0, "count");
            $display("Routing test %0d done", r);
        end
        finish_test;
    end
endmodule
